// [verif/aic_host_model.sv]
// APB host model that drives the command interpreter task file
`timescale 1ns/1ps
`default_nettype none
module aic_host_model (
    // Clock
    input wire logic pclk,
    // APB master
    output logic psel,
    output logic penable,
    output logic pwrite,
    output logic [7:0] paddr,
    output logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr
);
    int tmo = 0;
    logic err;
    initial begin
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'hff;
        pwdata = 32'h0;
    end
    // Plain APB cycles only, so no advanced timing mode is ever used
    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                        output logic [31:0] r);
        int n;
        n = 0;
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        if (n >= 50) tmo++;
        r = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        // Released bus shows garbage, never the last value
        paddr <= ~a;
        pwdata <= ~d;
    endtask
endmodule
`default_nettype wire

// [verif/test_aic_cmd_core.sv]
// Self-checking bench for the idle-command interpreter
`timescale 1ns/1ps
`default_nettype none
module test_aic_cmd_core;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel, penable, pwrite, pready, pslverr, irq, dma_start, powered_down;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, r, w;
    int failures = 0;
    int cmp_count = 0;
    int dmas = 0;
    int n;
    logic [15:0] bq[$];
    aic_pkg::aic_mode_cfg_t c;
    logic [2:0] pm, dm, ps, ds;
    always #4 pclk = ~pclk;
    always @(posedge pclk) if (dma_start === 1'b1) dmas++;
    // Short power-down tick and a tiny buffer keep the run brief
    aic_cmd_core #(.PD_TICK_CYC(10), .BUF_DEPTH(4)) dut (.pclk(pclk), .presetn(presetn),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .irq(irq),
        .dma_start(dma_start), .powered_down(powered_down));
    aic_host_model host (.pclk(pclk), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));
    task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            failures++;
            $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] x;
        host.xfer(1'b1, a, d, x);
        if (host.tmo != 0) summarize();
    endtask
    task automatic rd(input logic [7:0] a, output logic [31:0] q);
        host.xfer(1'b0, a, 32'h0, q);
        if (host.tmo != 0) summarize();
    endtask
    // Completion is one cycle after the command write and irq one cycle later; three cycles cover both
    task automatic cmd(input logic [7:0] op);
        wr(aic_pkg::OFF_CMD, {24'h0, op});
        repeat (3) @(posedge pclk);
        #1;
    endtask
    task automatic summarize;
        failures += host.tmo;
        $display("Comparisons %0d, mismatches %0d", cmp_count, failures);
        if (failures == 0 && cmp_count > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    initial begin
        repeat (100000) @(posedge pclk);
        failures++;
        summarize();
    end
    initial begin
        void'($urandom(32'h6edbec41));
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        rd(aic_pkg::OFF_IRQ_MASK, r);
        chk("mask_rst", r, 32'h0);
        rd(aic_pkg::OFF_GEOM, r);
        chk("geom_rst", r, 32'h100);
        repeat (16) begin
            c = aic_pkg::aic_mode_cfg_t'($urandom);
            wr(aic_pkg::OFF_MODE_CFG, {11'h0, c});
            pm = (c.pio_max > aic_pkg::ADV_MODE_MAX) ? 3'h0 : c.pio_max;
            dm = (c.mdma_max > aic_pkg::ADV_MODE_MAX) ? 3'h0 : c.mdma_max;
            ps = (c.pio_sel > pm) ? 3'h0 : c.pio_sel;
            ds = (c.mdma_sel > dm || c.udma_sel != 3'h0) ? 3'h0 : c.mdma_sel;
            rd(aic_pkg::OFF_ID163, r);
            chk("id163", r, {20'h0, ds, ps, dm, pm});
            rd(aic_pkg::OFF_ID164, r);
            chk("id164", r[5:0], {(c.mem_max > 3'h3) ? 3'h0 : c.mem_max,
                (c.io_max > 3'h3) ? 3'h0 : c.io_max});
        end
        cmd(aic_pkg::OP_IDLE_IMM_A);
        chk("irq_masked", irq, 1'b0);
        rd(aic_pkg::OFF_IRQ_STAT, r);
        chk("stat_imm", r, 32'h1);
        wr(aic_pkg::OFF_IRQ_STAT, 32'hf);
        wr(aic_pkg::OFF_IRQ_MASK, 32'hf);
        cmd(aic_pkg::OP_IDLE_IMM_B);
        chk("irq_imm", irq, 1'b1);
        rd(aic_pkg::OFF_STATUS, r);
        chk("idle_imm", r[3:0], 4'h8);
        wr(aic_pkg::OFF_IRQ_STAT, 32'hf);
        wr(aic_pkg::OFF_TASK, 32'h2);
        cmd(aic_pkg::OP_IDLE_A);
        n = 0;
        while (powered_down !== 1'b1 && n < 100) begin
            @(posedge pclk);
            n++;
        end
        chk("pd_time", n >= 16 && n <= 22, 1);
        if (n >= 100) summarize();
        rd(aic_pkg::OFF_STATUS, r);
        chk("pd_status", r[15:0], 16'h0238);
        rd(aic_pkg::OFF_IRQ_STAT, r);
        chk("pd_stat", r, 32'h9);
        wr(aic_pkg::OFF_TASK, 32'h0);
        cmd(aic_pkg::OP_IDLE_B);
        repeat (40) @(posedge pclk);
        chk("pd_off", powered_down, 1'b0);
        rd(aic_pkg::OFF_STATUS, r);
        chk("autopd_off", r[5:3], 3'b001);
        wr(aic_pkg::OFF_TASK, 32'hffeedd3f);
        wr(aic_pkg::OFF_DEVHEAD, 32'h07);
        cmd(aic_pkg::OP_INIT_PARAMS);
        rd(aic_pkg::OFF_GEOM, r);
        chk("geom", r, 32'h83f);
        wr(aic_pkg::OFF_IRQ_STAT, 32'hf);
        cmd(aic_pkg::OP_NOP);
        rd(aic_pkg::OFF_STATUS, r);
        chk("abort", r[2], 1'b1);
        rd(aic_pkg::OFF_IRQ_STAT, r);
        chk("nop_stat", r, 32'h5);
        wr(aic_pkg::OFF_TASK, 32'h12345607);
        wr(aic_pkg::OFF_DEVHEAD, 32'h4a);
        cmd(aic_pkg::OP_READ_DMA);
        chk("dma_pulse", dmas, 1);
        rd(aic_pkg::OFF_DMA_LBA, r);
        chk("dma_lba", r, 32'h0a123456);
        rd(aic_pkg::OFF_DMA_CNT, r);
        chk("dma_cnt", r, 32'h7);
        repeat (4) begin
            w = $urandom;
            bq.push_back(w[15:0]);
            wr(aic_pkg::OFF_BUF, {16'h0, w[15:0]});
        end
        wr(aic_pkg::OFF_IRQ_STAT, 32'hf);
        cmd(aic_pkg::OP_READ_BUF);
        repeat (4) begin
            rd(aic_pkg::OFF_BUF, r);
            chk("buf", r, {16'h0, bq.pop_front()});
        end
        rd(aic_pkg::OFF_IRQ_STAT, r);
        chk("buf_stat", r, 32'h3);
        rd(8'hfc, r);
        chk("unmapped", r, 32'h0);
        chk("slverr", host.err, 1'b1);
        summarize();
    end
endmodule
`default_nettype wire

// [verilog/aic_cmd_core.sv]
// Idle-type command interpreter with APB task file, sector buffer and interrupts
// Operation
// RL1: Report maximum advanced PIO mode, bits 2-0
// RL2: Report maximum advanced multiword DMA, bits 5-3
// RL3: Report selected advanced PIO mode, bits 8-6
// RL4: Report selected advanced multiword DMA, bits 11-9
// RL5: Timing word bits 15-12 reserved, zero
// RL6: Report fastest I/O cycle code, bits 2-0
// RL7: Report fastest memory cycle code, bits 5-3
// RL8: Host honours restrictions for fast PIO/DMA modes
// RL9: Host honours restrictions for fast bus cycles
// RL10: Idle: busy, idle, interrupt, arm 5ms timer
// RL11: Idle with zero count disables power-down
// RL12: Idle immediate: busy, idle, interrupt
// RL13: Init params: sectors from count, heads register
// RL14: Host gives heads minus one, mode bit zero
// RL15: NOP always aborts the command
// RL16: Read buffer returns buffer by PIO in
// RL17: DMA read address from task file fields
// RL18: Ultra and multiword DMA selections exclusive
// RL19: Selected mode never above supported maximum
`timescale 1ns/1ps
`default_nettype none
module aic_cmd_core #(
    parameter int unsigned PD_TICK_CYC = aic_pkg::PD_TICK_CYC,
    parameter int unsigned BUF_DEPTH = aic_pkg::BUF_DEPTH
) (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Device events
    output logic irq,
    output logic dma_start,
    output logic powered_down
);
    localparam int PW = $clog2(BUF_DEPTH);

    typedef enum logic [1:0] {AIC_READY, AIC_EXEC, AIC_DRQ} aic_state_t;

    aic_state_t state_q;
    aic_pkg::aic_task_t task_q;
    aic_pkg::aic_mode_cfg_t cfg_q;
    logic [7:0] devhead_q;
    logic [7:0] op_q;
    logic busy_q;
    logic abort_q;
    logic idle_q;
    logic autopd_q;
    logic [7:0] pd_count_q;
    logic [7:0] spt_q;
    logic [4:0] heads_q;
    logic [27:0] lba_q;
    logic [7:0] dma_cnt_q;
    logic [aic_pkg::IRQ_W-1:0] stat_q;
    logic [aic_pkg::IRQ_W-1:0] mask_q;
    logic [aic_pkg::IRQ_W-1:0] evt;
    logic [15:0] buf_q [BUF_DEPTH];
    logic [PW-1:0] rd_ptr_q;
    logic [PW-1:0] wr_ptr_q;
    logic [15:0] id163;
    logic [15:0] id164;
    logic [31:0] rd_mux;
    logic addr_ok;
    logic setup;
    logic wr_en;
    logic rd_en;
    logic cmd_go;
    logic is_idle;
    logic tmr_load;
    logic [7:0] tmr_count;
    logic tmr_expired;
    logic last_pop;

    assign setup = psel && !penable;
    assign wr_en = psel && penable && pready && pwrite;
    assign rd_en = psel && penable && pready && !pwrite;
    // Commands written while busy or transferring are ignored
    assign cmd_go = wr_en && paddr == aic_pkg::OFF_CMD && state_q == AIC_READY;
    assign is_idle = op_q == aic_pkg::OP_IDLE_A || op_q == aic_pkg::OP_IDLE_B;
    assign last_pop = rd_en && paddr == aic_pkg::OFF_BUF && state_q == AIC_DRQ
        && rd_ptr_q == PW'(BUF_DEPTH - 1);

    // Command sequencer and device status
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_q <= AIC_READY;
            op_q <= 8'h00;
            busy_q <= 1'b0;
            abort_q <= 1'b0;
            idle_q <= 1'b0;
            autopd_q <= 1'b0;
            pd_count_q <= 8'h00;
        end else begin
            case (state_q)
                AIC_READY: begin
                    if (cmd_go) begin
                        op_q <= pwdata[7:0];
                        busy_q <= 1'b1;
                        abort_q <= 1'b0;
                        state_q <= AIC_EXEC;
                    end
                end
                AIC_EXEC: begin
                    busy_q <= 1'b0;
                    state_q <= AIC_READY;
                    if (is_idle) begin
                        idle_q <= 1'b1; // [RL10]
                        autopd_q <= task_q.sec_cnt != 8'h00; // [RL10] [RL11]
                        pd_count_q <= task_q.sec_cnt; // [RL10]
                    end else if (op_q == aic_pkg::OP_IDLE_IMM_A
                            || op_q == aic_pkg::OP_IDLE_IMM_B) begin
                        idle_q <= 1'b1; // [RL12]
                    end else if (op_q == aic_pkg::OP_READ_BUF) begin
                        state_q <= AIC_DRQ; // [RL16]
                    end else if (op_q != aic_pkg::OP_INIT_PARAMS
                            && op_q != aic_pkg::OP_READ_DMA) begin
                        // NOP and any opcode outside this block end aborted
                        abort_q <= 1'b1; // [RL15]
                    end
                end
                AIC_DRQ: begin
                    if (last_pop) begin
                        state_q <= AIC_READY; // [RL16]
                    end
                end
                default: begin
                    state_q <= AIC_READY;
                end
            endcase
        end
    end

    // Completion events raised by the sequencer and the power-down timer expiry event
    always_comb begin
        evt = '0;
        if (state_q == AIC_EXEC) begin
            evt[aic_pkg::IRQ_DONE] = op_q != aic_pkg::OP_READ_BUF; // [RL10] [RL12]
            evt[aic_pkg::IRQ_DRQ] = op_q == aic_pkg::OP_READ_BUF; // [RL16]
            evt[aic_pkg::IRQ_ERR] = !is_idle && op_q != aic_pkg::OP_IDLE_IMM_A
                && op_q != aic_pkg::OP_IDLE_IMM_B && op_q != aic_pkg::OP_READ_BUF
                && op_q != aic_pkg::OP_INIT_PARAMS && op_q != aic_pkg::OP_READ_DMA; // [RL15]
        end
        if (last_pop) begin
            evt[aic_pkg::IRQ_DONE] = 1'b1;
        end
        evt[aic_pkg::IRQ_PWRDN] = tmr_expired;
    end

    // Task file and configuration writes
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            task_q <= '0;
            devhead_q <= 8'h00;
            cfg_q <= aic_pkg::MODE_CFG_RST;
            mask_q <= aic_pkg::IRQ_MASK_RST;
        end else if (wr_en) begin
            if (paddr == aic_pkg::OFF_TASK && state_q == AIC_READY) begin
                task_q <= aic_pkg::aic_task_t'(pwdata);
            end else if (paddr == aic_pkg::OFF_DEVHEAD && state_q == AIC_READY) begin
                devhead_q <= pwdata[7:0];
            end else if (paddr == aic_pkg::OFF_MODE_CFG) begin
                cfg_q <= aic_pkg::aic_mode_cfg_t'(pwdata[20:0]);
            end else if (paddr == aic_pkg::OFF_IRQ_MASK) begin
                mask_q <= pwdata[aic_pkg::IRQ_W-1:0];
            end
        end
    end

    // Geometry and DMA command capture
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            spt_q <= aic_pkg::SPT_RST;
            heads_q <= aic_pkg::HEADS_RST;
            lba_q <= 28'h0;
            dma_cnt_q <= 8'h00;
            dma_start <= 1'b0;
        end else begin
            dma_start <= 1'b0;
            if (state_q == AIC_EXEC && op_q == aic_pkg::OP_INIT_PARAMS) begin
                // Cylinder and sector number fields play no part
                spt_q <= task_q.sec_cnt; // [RL13]
                heads_q <= 5'({1'b0, devhead_q[3:0]}) + 5'h01; // [RL13] [RL14]
            end
            if (state_q == AIC_EXEC && op_q == aic_pkg::OP_READ_DMA) begin
                lba_q <= {devhead_q[3:0], task_q.cyl_hi, task_q.cyl_lo,
                    task_q.sec_num}; // [RL17]
                dma_cnt_q <= task_q.sec_cnt; // [RL17]
                dma_start <= 1'b1;
            end
        end
    end

    // Sector buffer: software fills it, the read-buffer command drains it
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rd_ptr_q <= '0;
            wr_ptr_q <= '0;
            for (int i = 0; i < BUF_DEPTH; i++) begin
                buf_q[i] <= 16'h0000;
            end
        end else begin
            if (state_q == AIC_EXEC && op_q == aic_pkg::OP_READ_BUF) begin
                rd_ptr_q <= '0; // [RL16]
            end else if (rd_en && paddr == aic_pkg::OFF_BUF && state_q == AIC_DRQ) begin
                rd_ptr_q <= rd_ptr_q + PW'(1); // [RL16]
            end
            if (wr_en && paddr == aic_pkg::OFF_BUF && state_q == AIC_READY) begin
                buf_q[wr_ptr_q] <= pwdata[15:0];
                wr_ptr_q <= wr_ptr_q + PW'(1);
            end
        end
    end

    // Any completed command restarts the power-down timer
    always_comb begin
        tmr_load = state_q == AIC_EXEC;
        if (is_idle) begin
            tmr_count = task_q.sec_cnt; // [RL10] [RL11]
        end else begin
            tmr_count = autopd_q ? pd_count_q : 8'h00;
        end
    end

    aic_pd_timer #(
        .TICK_CYC(PD_TICK_CYC)
    ) u_timer (
        .pclk(pclk),
        .presetn(presetn),
        .load(tmr_load),
        .count(tmr_count),
        .expired(tmr_expired)
    );

    // Expiry wins over a command arriving in the same cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            powered_down <= 1'b0;
        end else if (tmr_expired) begin
            powered_down <= 1'b1;
        end else if (cmd_go) begin
            powered_down <= 1'b0;
        end
    end

    // Sticky interrupt status, write one to clear; a new event beats the clear
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            stat_q <= '0;
            irq <= 1'b0;
        end else begin
            if (wr_en && paddr == aic_pkg::OFF_IRQ_STAT) begin
                stat_q <= (stat_q & ~pwdata[aic_pkg::IRQ_W-1:0]) | evt;
            end else begin
                stat_q <= stat_q | evt;
            end
            irq <= |(stat_q & mask_q);
        end
    end

    aic_id_words u_id (
        .cfg(cfg_q),
        .id163(id163),
        .id164(id164)
    );

    // Read decode
    always_comb begin
        rd_mux = 32'h0;
        addr_ok = 1'b1;
        if (paddr == aic_pkg::OFF_CMD) begin
            rd_mux = {24'h0, op_q};
        end else if (paddr == aic_pkg::OFF_TASK) begin
            rd_mux = task_q;
        end else if (paddr == aic_pkg::OFF_DEVHEAD) begin
            rd_mux = {24'h0, devhead_q};
        end else if (paddr == aic_pkg::OFF_STATUS) begin
            rd_mux[aic_pkg::ST_BUSY] = busy_q;
            rd_mux[aic_pkg::ST_DRQ] = state_q == AIC_DRQ;
            rd_mux[aic_pkg::ST_ABORT] = abort_q;
            rd_mux[aic_pkg::ST_IDLE] = idle_q;
            rd_mux[aic_pkg::ST_AUTOPD] = autopd_q;
            rd_mux[aic_pkg::ST_PWRDN] = powered_down;
            rd_mux[15:8] = pd_count_q;
        end else if (paddr == aic_pkg::OFF_IRQ_STAT) begin
            rd_mux = {28'h0, stat_q};
        end else if (paddr == aic_pkg::OFF_IRQ_MASK) begin
            rd_mux = {28'h0, mask_q};
        end else if (paddr == aic_pkg::OFF_ID163) begin
            rd_mux = {16'h0, id163};
        end else if (paddr == aic_pkg::OFF_ID164) begin
            rd_mux = {16'h0, id164};
        end else if (paddr == aic_pkg::OFF_MODE_CFG) begin
            rd_mux = {11'h0, cfg_q};
        end else if (paddr == aic_pkg::OFF_GEOM) begin
            rd_mux = {19'h0, heads_q, spt_q};
        end else if (paddr == aic_pkg::OFF_DMA_LBA) begin
            rd_mux = {4'h0, lba_q};
        end else if (paddr == aic_pkg::OFF_DMA_CNT) begin
            rd_mux = {24'h0, dma_cnt_q};
        end else if (paddr == aic_pkg::OFF_BUF) begin
            rd_mux = {16'h0, buf_q[rd_ptr_q]};
        end else begin
            addr_ok = 1'b0;
        end
    end

    // One wait-free access: data is captured in the setup cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h0;
        end else begin
            pready <= setup;
            pslverr <= setup && !addr_ok;
            if (setup) begin
                prdata <= rd_mux;
            end
        end
    end

    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);

    a_idle_busy_seq: assert property (cmd_go && (pwdata[7:0] == aic_pkg::OP_IDLE_IMM_A) // [RL12]
        |=> busy_q ##1 (!busy_q && idle_q && stat_q[aic_pkg::IRQ_DONE]))
        else $error("idle immediate did not pulse busy then interrupt");
    a_idle_arm_timer: assert property (cmd_go && pwdata[7:0] == aic_pkg::OP_IDLE_A // [RL10]
        && task_q.sec_cnt != 8'h00 |=> ##1 (autopd_q && pd_count_q == $past(task_q.sec_cnt, 2)))
        else $error("idle with nonzero count did not arm power-down");
    a_idle_zero_off: assert property (cmd_go && pwdata[7:0] == aic_pkg::OP_IDLE_B // [RL11]
        && task_q.sec_cnt == 8'h00 |=> ##1 !autopd_q)
        else $error("idle with zero count left power-down armed");
    a_nop_aborts: assert property (cmd_go && pwdata[7:0] == aic_pkg::OP_NOP // [RL15]
        |=> ##1 (abort_q && stat_q[aic_pkg::IRQ_ERR]))
        else $error("nop did not abort");
    a_init_geometry: assert property (state_q == AIC_EXEC // [RL13]
        && op_q == aic_pkg::OP_INIT_PARAMS |=> spt_q == $past(task_q.sec_cnt)
        && heads_q == 5'($past(devhead_q[3:0])) + 5'h01)
        else $error("drive parameters not taken from task file");
    a_dma_address: assert property ($rose(dma_start) // [RL17]
        |-> lba_q[27:24] == $past(devhead_q[3:0]) && lba_q[7:0] == $past(task_q.sec_num)
        && dma_cnt_q == $past(task_q.sec_cnt))
        else $error("dma address or count formed wrongly");
    a_rdbuf_drq: assert property (cmd_go && pwdata[7:0] == aic_pkg::OP_READ_BUF // [RL16]
        |=> ##1 (state_q == AIC_DRQ && rd_ptr_q == '0 && !busy_q))
        else $error("read buffer did not enter data-in phase");
    a_id_reserved: assert property (id163[15:12] == 4'h0 // [RL1] [RL5] [RL6] [RL7]
        && id163[2:0] <= 3'h2 && id164[2:0] <= 3'h3 && id164[5:3] <= 3'h3)
        else $error("identify timing word reports a reserved value");
    a_sel_le_max: assert property (id163[8:6] <= id163[2:0] // [RL19]
        && id163[11:9] <= id163[5:3])
        else $error("selected mode above supported maximum");
    a_dma_exclusive: assert property (cfg_q.udma_sel != 3'h0 |-> id163[11:9] == 3'h0) // [RL18]
        else $error("ultra and multiword dma both selected");
endmodule
`default_nettype wire

// [verilog/aic_id_words.sv]
// Builds the advanced timing identify words from the mode configuration
`timescale 1ns/1ps
`default_nettype none
module aic_id_words (
    // Configuration
    input wire aic_pkg::aic_mode_cfg_t cfg,
    // Identify words
    output logic [15:0] id163,
    output logic [15:0] id164
);
    logic [2:0] pio_max;
    logic [2:0] mdma_max;
    logic [2:0] pio_sel;
    logic [2:0] mdma_sel;
    logic [2:0] io_max;
    logic [2:0] mem_max;

    always_comb begin
        // Reserved codes are never reported; they fall back to the legacy word
        pio_max = (cfg.pio_max > aic_pkg::ADV_MODE_MAX) ? 3'h0 : cfg.pio_max; // [RL1]
        mdma_max = (cfg.mdma_max > aic_pkg::ADV_MODE_MAX) ? 3'h0 : cfg.mdma_max; // [RL2]
        // Selection above the supported maximum is reported as legacy
        pio_sel = (cfg.pio_sel > pio_max) ? 3'h0 : cfg.pio_sel; // [RL3] [RL19]
        mdma_sel = (cfg.mdma_sel > mdma_max) ? 3'h0 : cfg.mdma_sel; // [RL4] [RL19]
        // An active Ultra DMA selection hides any multiword selection
        if (cfg.udma_sel != 3'h0) begin
            mdma_sel = 3'h0; // [RL18]
        end
        io_max = (cfg.io_max > aic_pkg::BUS_CYCLE_MAX) ? 3'h0 : cfg.io_max; // [RL6]
        mem_max = (cfg.mem_max > aic_pkg::BUS_CYCLE_MAX) ? 3'h0 : cfg.mem_max; // [RL7]
        id163 = {4'h0, mdma_sel, pio_sel, mdma_max, pio_max}; // [RL5]
        id164 = {10'h000, mem_max, io_max};
    end
endmodule
`default_nettype wire

// [verilog/aic_pd_timer.sv]
// Automatic power-down timer with 5 ms tick divider
`timescale 1ns/1ps
`default_nettype none
module aic_pd_timer #(
    parameter int unsigned TICK_CYC = aic_pkg::PD_TICK_CYC
) (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // Control
    input wire logic load,
    input wire logic [7:0] count,
    // Event
    output logic expired
);
    logic [31:0] div_q;
    logic [7:0] remain_q;
    logic tick;

    assign tick = (div_q == TICK_CYC - 1);

    // Divider restarts on load so the first tick is a full period away
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            div_q <= 32'h0;
        end else if (load || tick) begin
            div_q <= 32'h0;
        end else if (remain_q != 8'h00) begin
            div_q <= div_q + 32'h1;
        end
    end

    // A count of zero leaves the timer disarmed
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            remain_q <= 8'h00;
            expired <= 1'b0;
        end else begin
            expired <= 1'b0;
            if (load) begin
                remain_q <= count;
            end else if (tick && remain_q != 8'h00) begin
                remain_q <= remain_q - 8'h01;
                expired <= (remain_q == 8'h01);
            end
        end
    end
endmodule
`default_nettype wire

// [verilog/aic_pkg.sv]
// Shared constants and carrier types for the idle-command interpreter
`default_nettype none
package aic_pkg;
    // Register byte offsets on the APB slave
    localparam logic [7:0] OFF_CMD = 8'h00;
    localparam logic [7:0] OFF_TASK = 8'h04;
    localparam logic [7:0] OFF_DEVHEAD = 8'h08;
    localparam logic [7:0] OFF_STATUS = 8'h0c;
    localparam logic [7:0] OFF_IRQ_STAT = 8'h10;
    localparam logic [7:0] OFF_IRQ_MASK = 8'h14;
    localparam logic [7:0] OFF_ID163 = 8'h18;
    localparam logic [7:0] OFF_ID164 = 8'h1c;
    localparam logic [7:0] OFF_MODE_CFG = 8'h20;
    localparam logic [7:0] OFF_GEOM = 8'h24;
    localparam logic [7:0] OFF_DMA_LBA = 8'h28;
    localparam logic [7:0] OFF_DMA_CNT = 8'h2c;
    localparam logic [7:0] OFF_BUF = 8'h30;

    // Command opcodes
    localparam logic [7:0] OP_IDLE_A = 8'h97;
    localparam logic [7:0] OP_IDLE_B = 8'he3;
    localparam logic [7:0] OP_IDLE_IMM_A = 8'h95;
    localparam logic [7:0] OP_IDLE_IMM_B = 8'he1;
    localparam logic [7:0] OP_INIT_PARAMS = 8'h91;
    localparam logic [7:0] OP_NOP = 8'h00;
    localparam logic [7:0] OP_READ_BUF = 8'he4;
    localparam logic [7:0] OP_READ_DMA = 8'hc8;

    // Interrupt status bit positions
    localparam int IRQ_DONE = 0;
    localparam int IRQ_DRQ = 1;
    localparam int IRQ_ERR = 2;
    localparam int IRQ_PWRDN = 3;
    localparam int IRQ_W = 4;

    // Status register bit positions
    localparam int ST_BUSY = 0;
    localparam int ST_DRQ = 1;
    localparam int ST_ABORT = 2;
    localparam int ST_IDLE = 3;
    localparam int ST_AUTOPD = 4;
    localparam int ST_PWRDN = 5;

    // Reset values
    localparam logic [3:0] IRQ_MASK_RST = 4'h0;
    localparam logic [7:0] SPT_RST = 8'h00;
    localparam logic [4:0] HEADS_RST = 5'h01;

    // Mode encodings in the identify words
    localparam logic [2:0] ADV_MODE_MAX = 3'h2;
    localparam logic [2:0] BUS_CYCLE_MAX = 3'h3;

    // Auto power-down time base
    localparam int unsigned PD_TICK_MS = 5;
    localparam int unsigned CLK_KHZ = 125000;
    localparam int unsigned PD_TICK_CYC = PD_TICK_MS * CLK_KHZ;

    // Sector buffer depth in 16-bit words
    localparam int unsigned BUF_DEPTH = 256;

    // Task-file fields written as one word at OFF_TASK
    typedef struct packed {
        logic [7:0] cyl_hi;
        logic [7:0] cyl_lo;
        logic [7:0] sec_num;
        logic [7:0] sec_cnt;
    } aic_task_t;

    // Timing-mode configuration written at OFF_MODE_CFG
    typedef struct packed {
        logic [2:0] udma_sel;
        logic [2:0] mem_max;
        logic [2:0] io_max;
        logic [2:0] mdma_sel;
        logic [2:0] pio_sel;
        logic [2:0] mdma_max;
        logic [2:0] pio_max;
    } aic_mode_cfg_t;

    localparam aic_mode_cfg_t MODE_CFG_RST = '0;
endpackage
`default_nettype wire
